// file: logic/dtpb_builder.sv
// dtpb_builder: turns one dispatch request into the register stream a shader thread receives.
// assumes requester, data source, payload sink and retire port all run on CLK.
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module dtpb_builder #(
  parameter int IDX_W = 9,
  parameter int TAG_W = 24
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // register port
  input wire logic [3:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  // dispatch request
  input wire logic REQ_VALID,
  input wire dtpb_pkg::dtpb_req_t REQ,
  output logic REQ_READY,
  // pushed constant then patch data
  input wire logic DATA_VALID,
  input wire logic [dtpb_pkg::DTPB_REG_W-1:0] DATA,
  output logic DATA_READY,
  // thread retire
  input wire logic DONE_VALID,
  input wire logic [IDX_W-1:0] DONE_INDEX,
  // payload stream
  output logic PAY_VALID,
  input wire logic PAY_READY,
  output dtpb_pkg::dtpb_beat_t PAY
);
  import dtpb_pkg::*;

  // ==========================================================
  // helpers
  // truncating float add; denormals flush to zero to keep the adder small
  function automatic logic [31:0] fadd(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] x;
    logic [31:0] y;
    logic [25:0] mx;
    logic [25:0] my;
    logic [25:0] ms;
    logic [7:0] e;
    logic [7:0] d;
    x = a;
    y = b;
    if (a[30:0] < b[30:0]) begin
      x = b;
      y = a;
    end
    mx = {1'b0, x[30:23] != 8'h00, x[22:0], 1'b0};
    my = {1'b0, y[30:23] != 8'h00, y[22:0], 1'b0};
    if (y[30:23] == 8'h00) my = '0;
    e = x[30:23];
    d = x[30:23] - y[30:23];
    my = (d > 8'h19) ? 26'h0 : my >> d;
    ms = (x[31] == y[31]) ? mx + my : mx - my;
    if (ms[25]) begin
      ms = ms >> 1;
      e = e + 8'h01;
    end
    for (int i = 0; i < 25; i++) begin
      if (!ms[24] && ms != 26'h0 && e != 8'h00) begin
        ms = ms << 1;
        e = e - 8'h01;
      end
    end
    fadd = (ms == 26'h0 || e == 8'h00) ? DTPB_F_ZERO : {x[31], e, ms[23:1]};
  endfunction

  function automatic logic [31:0] wcoord(input logic cw, input logic [31:0] u, input logic [31:0] v);
    wcoord = cw ? fadd(fadd(DTPB_F_ONE, {~u[31], u[30:0]}), {~v[31], v[30:0]}) : DTPB_F_ZERO;
  endfunction

  function automatic logic [7:0] lanes(input logic [3:0] n);
    lanes = (n >= 4'h8) ? 8'hFF : 8'((9'h001 << n) - 9'h001);
  endfunction

  // ==========================================================
  // registers
  logic [31:0] ctrl_reg;
  logic [31:0] const_reg;
  logic [31:0] patch_reg;
  logic [TAG_W-1:0] tag_reg;
  logic busy_st;

  logic [7:0] const_sum;
  always_comb begin
    const_sum = 8'h00;
    for (int i = 0; i < DTPB_NBUF; i++) begin
      if (const_reg[DTPB_CEN_LSB+i]) const_sum = const_sum + 8'(const_reg[i*DTPB_CLEN_W +: DTPB_CLEN_W]);
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_reg <= DTPB_CTRL_RST;
      const_reg <= DTPB_CONST_RST;
      patch_reg <= DTPB_PATCH_RST;
    end else if (REG_WR) begin
      case (REG_ADDR)
        DTPB_ADDR_CTRL: ctrl_reg <= {31'h0, REG_WDATA[DTPB_CTRL_CW_BIT]};
        DTPB_ADDR_CONST: const_reg <= {4'h0, REG_WDATA[27:0]};
        DTPB_ADDR_PATCH: patch_reg <= {26'h0, REG_WDATA[5:0]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      REG_RDATA <= 32'h0000_0000;
    end else if (REG_RD) begin
      case (REG_ADDR)
        DTPB_ADDR_CTRL: REG_RDATA <= ctrl_reg;
        DTPB_ADDR_CONST: REG_RDATA <= const_reg;
        DTPB_ADDR_PATCH: REG_RDATA <= patch_reg;
        DTPB_ADDR_STAT: REG_RDATA <= {7'h00, tag_reg, busy_st};
        default: REG_RDATA <= 32'h0000_0000;
      endcase
    end else begin
      REG_RDATA <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // outstanding thread index pool
  logic [(1<<IDX_W)-1:0] busy_reg;
  logic [IDX_W-1:0] idx_reg;
  logic accept;

  // set wins over a retire of the same index in the same cycle
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      busy_reg <= '0;
      idx_reg <= '0;
    end else begin
      if (DONE_VALID) busy_reg[DONE_INDEX] <= 1'b0;
      if (accept) begin
        busy_reg[idx_reg] <= 1'b1;
        idx_reg <= idx_reg + IDX_W'(1);
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) tag_reg <= '0;
    else if (accept) tag_reg <= tag_reg + TAG_W'(1);
  end

  // ==========================================================
  // sequencer
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PT = 4'b0010,
    ST_CON = 4'b0100,
    ST_PAT = 4'b1000
  } dtpb_state_t;

  dtpb_state_t state_reg, state_next;
  dtpb_req_t req_reg;
  logic cw_reg;
  logic [7:0] cnum_reg;
  logic [5:0] pnum_reg;
  logic [7:0] beat_reg, beat_next;
  logic pay_valid_reg;
  dtpb_beat_t pay_reg;
  logic emit;
  dtpb_beat_t emit_beat;
  logic slot_free;
  logic [7:0] npt;

  assign slot_free = !pay_valid_reg || PAY_READY;
  assign busy_st = (state_reg != ST_IDLE);
  assign REQ_READY = (state_reg == ST_IDLE) && !busy_reg[idx_reg] && slot_free;
  assign accept = REQ_VALID && REQ_READY;
  assign DATA_READY = (state_reg == ST_CON || state_reg == ST_PAT) && slot_free;
  assign PAY_VALID = pay_valid_reg;
  assign PAY = pay_reg;

  always_comb begin
    case (req_reg.layout)
      DTPB_TWO_VERTEX: npt = 8'h01;
      DTPB_EIGHT_LANE: npt = 8'h04;
      default: npt = 8'h05;
    endcase
  end

  // header register, built straight from the request at acceptance
  function automatic logic [255:0] header(input dtpb_req_t r, input logic [IDX_W-1:0] idx,
                                           input logic [TAG_W-1:0] tag);
    logic [255:0] h;
    h = '0;
    if (r.layout == DTPB_TWO_VERTEX) begin
      h[0 +: DTPB_H14_W] = r.handle[0][DTPB_H14_W-1:0];
      h[32 +: DTPB_H14_W] = r.handle[1][DTPB_H14_W-1:0];
    end else begin
      h[0 +: DTPB_H16_W] = r.patch0;
      if (r.layout == DTPB_EIGHT_LANE) h[32 +: 32] = r.prim0;
      else h[32 +: DTPB_H16_W] = r.patch1;
    end
    h[96 +: 4] = (r.scr_size > DTPB_SCR_MAX) ? DTPB_SCR_MAX : r.scr_size;
    h[96 + DTPB_PTR_LSB +: 27] = r.samp_ptr;
    h[128 + DTPB_PTR_LSB +: 27] = r.bind_ptr;
    h[160 +: IDX_W] = idx;
    h[160 + DTPB_SCR_LSB +: 22] = r.scr_off;
    h[192 +: TAG_W] = tag;
    header = h;
  endfunction

  // point registers that follow the header
  function automatic logic [255:0] points(input dtpb_req_t r, input logic cw, input logic [7:0] k);
    logic [255:0] p;
    logic [7:0] s;
    p = '0;
    s = (r.layout == DTPB_DUAL_PATCH) ? k - 8'h01 : k;
    if (r.layout == DTPB_TWO_VERTEX) begin
      p[0 +: 32] = r.u[0];
      p[32 +: 32] = r.v[0];
      p[64 +: 32] = wcoord(cw, r.u[0], r.v[0]);
      p[96 +: DTPB_H14_W] = r.patch0[DTPB_H14_W-1:0];
      p[128 +: 32] = r.u[1];
      p[160 +: 32] = r.v[1];
      p[192 +: 32] = wcoord(cw, r.u[1], r.v[1]);
      p[224 +: 32] = r.prim0;
    end else if (s == 8'h00) begin
      p[0 +: 32] = r.prim0;
      p[128 +: 32] = r.prim1;
    end else begin
      for (int i = 0; i < DTPB_LANES; i++) begin
        case (s)
          8'h01: p[i*32 +: 32] = r.u[i];
          8'h02: p[i*32 +: 32] = r.v[i];
          8'h03: p[i*32 +: 32] = wcoord(cw, r.u[i], r.v[i]);
          default: p[i*32 +: DTPB_H16_W] = r.handle[i];
        endcase
      end
    end
    points = p;
  endfunction

  logic [7:0] pmask;
  logic [7:0] lane_lo;
  logic [7:0] lane_hi;
  assign lane_lo = lanes(req_reg.cnt0);
  assign lane_hi = lanes({1'b0, req_reg.cnt1});
  always_comb begin
    case (req_reg.layout)
      DTPB_TWO_VERTEX: pmask = (req_reg.cnt0 < 4'h2) ? 8'h0F : 8'hFF;
      DTPB_EIGHT_LANE: pmask = lane_lo;
      default: pmask = {lane_hi[3:0], lane_lo[3:0]};
    endcase
  end

  always_comb begin
    state_next = state_reg;
    beat_next = beat_reg;
    emit = 1'b0;
    emit_beat = '0;
    emit_beat.mask = pmask;
    case (state_reg)
      ST_IDLE: begin
        if (accept) begin
          emit = 1'b1;
          emit_beat.data = header(REQ, idx_reg, tag_reg);
          emit_beat.mask = 8'h00;
          state_next = ST_PT;
          beat_next = 8'h01;
        end
      end
      ST_PT: begin
        if (slot_free) begin
          emit = 1'b1;
          emit_beat.data = points(req_reg, cw_reg, beat_reg);
          beat_next = beat_reg + 8'h01;
          if (beat_reg == npt) begin
            beat_next = 8'h01;
            if (cnum_reg != 8'h00) state_next = ST_CON;
            else if (pnum_reg != 6'h00) state_next = ST_PAT;
            else state_next = ST_IDLE;
            emit_beat.last = (cnum_reg == 8'h00) && (pnum_reg == 6'h00);
          end
        end
      end
      ST_CON: begin
        if (DATA_READY && DATA_VALID) begin
          emit = 1'b1;
          emit_beat.data = DATA;
          beat_next = beat_reg + 8'h01;
          if (beat_reg == cnum_reg) begin
            beat_next = 8'h01;
            state_next = (pnum_reg != 6'h00) ? ST_PAT : ST_IDLE;
            emit_beat.last = (pnum_reg == 6'h00);
          end
        end
      end
      ST_PAT: begin
        if (DATA_READY && DATA_VALID) begin
          emit = 1'b1;
          emit_beat.data = DATA;
          beat_next = beat_reg + 8'h01;
          if (beat_reg == {2'b00, pnum_reg}) begin
            state_next = ST_IDLE;
            emit_beat.last = 1'b1;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= ST_IDLE;
      beat_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      beat_reg <= beat_next;
    end
  end

  // request and length snapshot, so register writes mid-thread do not tear a payload
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      req_reg <= '0;
      cw_reg <= 1'b0;
      cnum_reg <= 8'h00;
      pnum_reg <= 6'h00;
    end else if (accept) begin
      req_reg <= REQ;
      cw_reg <= ctrl_reg[DTPB_CTRL_CW_BIT];
      cnum_reg <= const_sum;
      pnum_reg <= patch_reg[5:0];
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pay_valid_reg <= 1'b0;
      pay_reg <= '0;
    end else if (emit) begin
      pay_valid_reg <= 1'b1;
      pay_reg <= emit_beat;
    end else if (PAY_READY) begin
      pay_valid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // checks
  logic out_hdr_reg;
  logic [7:0] out_k_reg;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      out_hdr_reg <= 1'b0;
      out_k_reg <= 8'h00;
    end else if (emit) begin
      out_hdr_reg <= (state_reg == ST_IDLE);
      out_k_reg <= (state_reg == ST_PT) ? beat_reg : 8'h00;
    end
  end

  logic pt_tv;
  assign pt_tv = PAY_VALID && out_k_reg == 8'h01 && req_reg.layout == DTPB_TWO_VERTEX;

  hdr_dw2_zero_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    PAY_VALID && out_hdr_reg |-> PAY.data[64 +: 32] == 32'h0)
    else $error("header dword 2 not zero");
  scratch_range_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    PAY_VALID && out_hdr_reg |-> PAY.data[96 +: 4] <= DTPB_SCR_MAX)
    else $error("scratch size out of range");
  tag_step_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    accept |=> PAY.data[192 +: TAG_W] == $past(tag_reg) && tag_reg == $past(tag_reg) + TAG_W'(1))
    else $error("thread tag not fresh");
  index_hold_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    accept |=> busy_reg[PAY.data[160 +: IDX_W]] && PAY.data[160 +: IDX_W] == $past(idx_reg))
    else $error("index not held busy");
  tv_prim_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    pt_tv |-> PAY.data[224 +: 32] == req_reg.prim0)
    else $error("primitive id misplaced");
  w_zero_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    pt_tv && !cw_reg |-> PAY.data[64 +: 32] == DTPB_F_ZERO && PAY.data[192 +: 32] == DTPB_F_ZERO)
    else $error("w not zero when disabled");
  single_mask_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    pt_tv && req_reg.cnt0 < 4'h2 |-> PAY.mask[7:4] == 4'h0)
    else $error("upper channels enabled");
  hdr_rsvd_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    PAY_VALID && out_hdr_reg |-> PAY.data[224 +: 32] == 32'h0 && PAY.data[160 + IDX_W +: DTPB_SCR_LSB - IDX_W] == '0)
    else $error("reserved header bits set");
  beat_hold_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    PAY_VALID && !PAY_READY |=> PAY_VALID && $stable(PAY))
    else $error("payload beat dropped");
  handle_hi_a: assert property (@(posedge CLK) disable iff (!RESET_N)
    PAY_VALID && out_k_reg == 8'h04 && req_reg.layout == DTPB_EIGHT_LANE |-> PAY.data[16 +: 16] == 16'h0)
    else $error("handle upper bits set");

  tv_done_c: cover property (@(posedge CLK) disable iff (!RESET_N)
    accept && REQ.layout == DTPB_TWO_VERTEX ##[1:4] PAY_VALID && PAY_READY && PAY.last);
  dual_const_c: cover property (@(posedge CLK) disable iff (!RESET_N)
    state_reg == ST_CON && req_reg.layout == DTPB_DUAL_PATCH && DATA_VALID && DATA_READY);
  stall_c: cover property (@(posedge CLK) disable iff (!RESET_N) PAY_VALID && !PAY_READY ##1 PAY_READY);

endmodule

`default_nettype wire

// file: pkg/dtpb_pkg.sv
// dtpb_pkg: constants and carrier types for the domain thread payload builder.
// assumes one clock domain; every file that uses it imports dtpb_pkg::*.
//
// Behaviour
// - two-vertex: header dword 0 bits 13:0 carry vertex 0 return handle.
// - two-vertex: header dword 1 bits 13:0 carry vertex 1 return handle.
// - one shaded vertex: channel mask stores nothing for upper channels.
// - header dword 2 is always all zeros.
// - dword 3 bits 3:0 scratch size, power of two over ten, 0 to 11.
// - dword 5 bits 31:10 carry the 1 KB scratch offset.
// - dword 4 bits 31:5 carry the binding table pointer.
// - dword 3 bits 31:5 carry the sampler state pointer.
// - dword 6 bits 23:0 carry a thread tag unique over time.
// - dword 5 bits 8:0 carry the outstanding thread index.
// - two-vertex: primitive id in dword 7 of the second register.
// - two-vertex: point 0 U V W in dwords 0-2, point 1 in 4-6.
// - W is 1 minus U minus V when enabled, else 0.0.
// - two-vertex: patch record handle in dword 3 bits 13:0.
// - constant data follows, length the sum of enabled read lengths.
// - patch data follows, length the patch read length.
// - eight-lane: header dword 1 carries the primitive id.
// - eight-lane: header dword 0 bits 15:0 carry the patch offset.
// - eight-lane: U, V, W of points 0-7 in registers two to four.
// - eight-lane: fifth register holds 16-bit return handles per point.
// - two-patch: lower four channels patch 0, upper four patch 1.
package dtpb_pkg;

  localparam int DTPB_LANES = 8;
  localparam int DTPB_REG_W = 256;

  // register port
  localparam logic [3:0] DTPB_ADDR_CTRL = 4'h0;
  localparam logic [3:0] DTPB_ADDR_CONST = 4'h4;
  localparam logic [3:0] DTPB_ADDR_PATCH = 4'h8;
  localparam logic [3:0] DTPB_ADDR_STAT = 4'hC;
  localparam logic [31:0] DTPB_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] DTPB_CONST_RST = 32'h0000_0000;
  localparam logic [31:0] DTPB_PATCH_RST = 32'h0000_0000;
  localparam int DTPB_CTRL_CW_BIT = 0;
  localparam int DTPB_CLEN_W = 6;
  localparam int DTPB_CEN_LSB = 24;
  localparam int DTPB_NBUF = 4;

  // header field positions
  localparam int DTPB_H14_W = 14;
  localparam int DTPB_H16_W = 16;
  localparam int DTPB_PTR_LSB = 5;
  localparam int DTPB_SCR_LSB = 10;
  localparam logic [3:0] DTPB_SCR_MAX = 4'hB;

  localparam logic [31:0] DTPB_F_ONE = 32'h3F80_0000;
  localparam logic [31:0] DTPB_F_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    DTPB_TWO_VERTEX = 2'h0,
    DTPB_EIGHT_LANE = 2'h1,
    DTPB_DUAL_PATCH = 2'h2
  } dtpb_layout_t;

  typedef struct packed {
    dtpb_layout_t layout;
    logic [3:0] cnt0;
    logic [2:0] cnt1;
    logic [7:0][15:0] handle;
    logic [15:0] patch0;
    logic [15:0] patch1;
    logic [31:0] prim0;
    logic [31:0] prim1;
    logic [7:0][31:0] u;
    logic [7:0][31:0] v;
    logic [3:0] scr_size;
    logic [21:0] scr_off;
    logic [26:0] bind_ptr;
    logic [26:0] samp_ptr;
  } dtpb_req_t;

  typedef struct packed {
    logic [DTPB_REG_W-1:0] data;
    logic [DTPB_LANES-1:0] mask;
    logic last;
  } dtpb_beat_t;

endpackage

// file: testbench/dtpb_builder_tb.sv
// dtpb_builder_tb: self-checking bench for the payload builder.
// assumes dtpb_pkg and dtpb_eu_model are compiled first.
`timescale 1ns/1ns
`default_nettype none

module dtpb_builder_tb;
  import dtpb_pkg::*;
  typedef struct {dtpb_layout_t lay; logic cw; logic [3:0] c0; logic [2:0] c1; logic [3:0] scr;
    logic st; logic [31:0] cst; logic [5:0] pat; logic [7:0] m;} dtpb_row_t;
  // u values 0.0, 0.25, 0.5, 0.75 with v 0.25 keep every w exact
  localparam logic [3:0][31:0] UV = {32'h3F40_0000, 32'h3F00_0000, 32'h3E80_0000, 32'h0000_0000};
  logic clk = 1'h0, reset_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, req_valid = 1'h0, data_valid = 1'h0;
  logic stall = 1'h0, retire = 1'h1, cw_cur, req_ready, data_ready, done_valid, pay_valid, pay_ready;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [255:0] data = '0;
  logic [255:0] eq[$];
  logic [8:0] done_index;
  logic [5:0] pat_cur;
  dtpb_req_t req = '0;
  dtpb_beat_t pay;
  dtpb_row_t rows[6];
  int failures = 0, checks_done = 0, nacc = 0, ncst;

  dtpb_builder u_dtpb_builder (.CLK(clk), .RESET_N(reset_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .REQ_VALID(req_valid), .REQ(req),
    .REQ_READY(req_ready), .DATA_VALID(data_valid), .DATA(data), .DATA_READY(data_ready),
    .DONE_VALID(done_valid), .DONE_INDEX(done_index), .PAY_VALID(pay_valid), .PAY_READY(pay_ready), .PAY(pay));
  dtpb_eu_model u_dtpb_eu_model (.CLK(clk), .RESET_N(reset_n), .PAY_VALID(pay_valid), .PAY(pay),
    .PAY_READY(pay_ready), .DONE_VALID(done_valid), .DONE_INDEX(done_index), .STALL(stall), .RETIRE(retire));

  initial begin
    forever #5 clk = ~clk;
  end

  // ====================
  // helpers
  task automatic end_sim;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [255:0] g, input logic [255:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
    @(posedge clk);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 chk(reg_rdata, e);
    @(posedge clk);
  endtask

  function automatic logic [31:0] wv(input logic [31:0] u);
    if (!cw_cur) return 32'h0;
    return (u == UV[0]) ? UV[3] : (u == UV[1]) ? UV[2] : (u == UV[2]) ? UV[1] : UV[0];
  endfunction

  task automatic send(input dtpb_req_t r);
    int n;
    n = 0;
    req <= r;
    req_valid <= 1'h1;
    #1;
    while (req_ready !== 1'h1 && n < 200) begin
      @(posedge clk);
      #1 n++;
    end
    if (n == 200) chk(1'h0, 1'h1);
    @(posedge clk);
    req_valid <= 1'h0;
    #1 chk(req_ready, 1'h0);
  endtask

  task automatic drive_data(input int nd);
    int n;
    n = 0;
    for (int i = 0; i < nd; i++) begin
      data <= {8{32'hD000_0000 | 32'(i)}};
      data_valid <= 1'h1;
      #1;
      while (data_ready !== 1'h1 && n < 400) begin
        @(posedge clk);
        #1 n++;
      end
      @(posedge clk);
    end
    data_valid <= 1'h0;
    data <= ~data;
  endtask

  task automatic run(input dtpb_row_t rw);
    dtpb_req_t r;
    logic [7:0][31:0] b;
    dtpb_beat_t g[$];
    int n;
    r = '0;
    r.layout = rw.lay;
    {r.cnt0, r.cnt1, r.scr_size} = {rw.c0, rw.c1, rw.scr};
    {r.patch0, r.patch1, r.prim0, r.prim1} = {16'h2A51, 16'h1B62, 32'hA5A5_0001, 32'h5A5A_0002};
    {r.scr_off, r.bind_ptr, r.samp_ptr} = {22'h2A_AAAA, 27'h555_5555, 27'h2AA_AAAA};
    for (int k = 0; k < 8; k++) begin
      r.handle[k] = 16'h1100 | 16'(k);
      r.u[k] = UV[k % 4];
      r.v[k] = UV[1];
    end
    eq.delete();
    b = '0;
    case (rw.lay)
      DTPB_TWO_VERTEX: {b[1], b[0]} = {18'h0, r.handle[1][13:0], 18'h0, r.handle[0][13:0]};
      DTPB_EIGHT_LANE: {b[1], b[0]} = {r.prim0, 16'h0, r.patch0};
      default: {b[1], b[0]} = {16'h0, r.patch1, 16'h0, r.patch0};
    endcase
    b[3] = {r.samp_ptr, 1'h0, (rw.scr > 4'hB) ? 4'hB : rw.scr};
    b[4] = {r.bind_ptr, 5'h0};
    b[5] = {r.scr_off, 1'h0, 9'(nacc)};
    b[6] = {8'h0, 24'(nacc)};
    eq.push_back(b);
    if (rw.lay == DTPB_TWO_VERTEX) begin
      eq.push_back({r.prim0, wv(r.u[1]), r.v[1], r.u[1], 18'h0, r.patch0[13:0], wv(r.u[0]), r.v[0], r.u[0]});
    end else begin
      if (rw.lay == DTPB_DUAL_PATCH) eq.push_back({96'h0, r.prim1, 96'h0, r.prim0});
      eq.push_back(r.u);
      eq.push_back(r.v);
      for (int k = 0; k < 8; k++) begin
        b[k] = wv(r.u[k]);
      end
      eq.push_back(b);
      for (int k = 0; k < 8; k++) begin
        b[k] = {16'h0, r.handle[k]};
      end
      eq.push_back(b);
    end
    for (int i = 0; i < ncst + pat_cur; i++) begin
      eq.push_back({8{32'hD000_0000 | 32'(i)}});
    end
    stall <= rw.st;
    fork
      send(r);
      drive_data(ncst + pat_cur);
    join
    n = 0;
    while (u_dtpb_eu_model.got.size() < eq.size() && n < 500) begin
      @(posedge clk);
      n++;
    end
    repeat (3) @(posedge clk);
    g = u_dtpb_eu_model.got;
    chk(g.size(), eq.size());
    chk(g[0].data, eq[0]);
    chk(g[1].mask, rw.m);
    for (int k = 1; k < eq.size() && k < g.size(); k++) begin
      chk(g[k].data, eq[k]);
      chk(g[k].last, k == eq.size() - 1);
    end
    u_dtpb_eu_model.got.delete();
    nacc++;
  endtask

  // ====================
  // sequence
  initial begin
    rows = '{
      '{DTPB_TWO_VERTEX, 1'h0, 4'h1, 3'h0, 4'h0, 1'h0, 32'h0, 6'h0, 8'h0F},
      '{DTPB_TWO_VERTEX, 1'h1, 4'h2, 3'h0, 4'hB, 1'h1, 32'h0, 6'h0, 8'hFF},
      '{DTPB_EIGHT_LANE, 1'h1, 4'h8, 3'h0, 4'hF, 1'h1, 32'h0504_3081, 6'h2, 8'hFF},
      '{DTPB_EIGHT_LANE, 1'h0, 4'h3, 3'h0, 4'h5, 1'h0, 32'h0F04_3081, 6'h0, 8'h07},
      '{DTPB_DUAL_PATCH, 1'h1, 4'h4, 3'h2, 4'h1, 1'h1, 32'h0, 6'h1, 8'h3F},
      '{DTPB_DUAL_PATCH, 1'h0, 4'h1, 3'h4, 4'h0, 1'h0, 32'h0A04_3081, 6'h3, 8'hF1}
    };
    repeat (5) @(posedge clk);
    reset_n <= 1'h1;
    @(posedge clk);
    foreach (rows[i]) begin
      cw_cur = rows[i].cw;
      pat_cur = rows[i].pat;
      ncst = 0;
      for (int j = 0; j < 4; j++) begin
        if (rows[i].cst[24 + j]) ncst += int'(rows[i].cst[6 * j +: 6]);
      end
      wr(DTPB_ADDR_CTRL, {31'h0, rows[i].cw});
      wr(DTPB_ADDR_CONST, rows[i].cst);
      wr(DTPB_ADDR_PATCH, {26'h0, rows[i].pat});
      run(rows[i]);
      $display("test row %0d done", i);
    end
    rdc(DTPB_ADDR_STAT, {7'h0, 24'(nacc), 1'h0});
    wr(DTPB_ADDR_CTRL, 32'hFFFF_FFFF);
    wr(DTPB_ADDR_CONST, 32'hFFFF_FFFF);
    wr(DTPB_ADDR_PATCH, 32'hFFFF_FFFF);
    wr(4'h2, 32'hFFFF_FFFF);
    rdc(DTPB_ADDR_CTRL, 32'h1);
    rdc(DTPB_ADDR_CONST, 32'h0FFF_FFFF);
    rdc(DTPB_ADDR_PATCH, 32'h3F);
    rdc(4'h2, 32'h0);
    $display("test register access done");
    reset_n <= 1'h0;
    #1 chk({pay_valid, req_ready, data_ready, pay.mask, pay.last, reg_rdata}, {3'h2, 9'h0, 32'h0});
    chk(pay.data, '0);
    repeat (5) @(posedge clk);
    reset_n <= 1'h1;
    nacc = 0;
    @(posedge clk);
    rdc(DTPB_ADDR_CTRL, DTPB_CTRL_RST);
    rdc(DTPB_ADDR_CONST, DTPB_CONST_RST);
    rdc(DTPB_ADDR_PATCH, DTPB_PATCH_RST);
    rdc(DTPB_ADDR_STAT, 32'h0);
    $display("test reset done");
    // with retire held off every index stays busy, so the pool must fill
    cw_cur = 1'h0;
    pat_cur = 6'h0;
    ncst = 0;
    retire <= 1'h0;
    for (int i = 0; i < 512; i++) begin
      run(rows[0]);
    end
    req_valid <= 1'h1;
    repeat (20) @(posedge clk);
    #1 chk(req_ready, 1'h0);
    @(posedge clk);
    retire <= 1'h1;
    run(rows[0]);
    $display("test index pool done");
    end_sim;
  end

  initial begin
    #600_000;
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim;
  end
endmodule
`default_nettype wire

// file: testbench/dtpb_eu_model.sv
// dtpb_eu_model: execution-unit side, takes payload beats and retires threads.
// assumes the bench reads the captured beats and sets the stall and retire controls.
`timescale 1ns/1ns
`default_nettype none

module dtpb_eu_model
  import dtpb_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // payload stream
  input wire logic PAY_VALID,
  input wire dtpb_pkg::dtpb_beat_t PAY,
  output logic PAY_READY,
  // thread retire
  output logic DONE_VALID,
  output logic [8:0] DONE_INDEX,
  // bench controls
  input wire logic STALL,
  input wire logic RETIRE
);
  // ====================
  // capture and retire
  dtpb_beat_t got[$];
  logic [8:0] pend[$];
  logic [8:0] idx_reg;
  logic [1:0] cnt_reg;
  logic first_reg;

  // a stalling thread takes one beat in four, so held beats get exercised
  assign PAY_READY = !STALL || (cnt_reg == 2'h0);

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      got.delete();
      pend.delete();
      first_reg <= 1'h1;
      idx_reg <= 9'h0;
      cnt_reg <= 2'h0;
      DONE_VALID <= 1'h0;
      DONE_INDEX <= 9'h0;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
      if (PAY_VALID && PAY_READY) begin
        got.push_back(PAY);
        // header is never the last beat, so the index is in place by the last one
        if (first_reg) begin
          idx_reg <= PAY.data[168:160];
        end
        first_reg <= PAY.last;
        if (PAY.last) begin
          pend.push_back(idx_reg);
        end
      end
      // index only means something beside the pulse, so it wanders otherwise
      if (RETIRE && pend.size() > 0) begin
        DONE_VALID <= 1'h1;
        DONE_INDEX <= pend.pop_front();
      end else begin
        DONE_VALID <= 1'h0;
        DONE_INDEX <= ~DONE_INDEX;
      end
    end
  end
endmodule
`default_nettype wire
